// >>> src/pin_irq_cfg.svh
// offsets, field positions, reset values and timing counts of the pin interrupt block
// assumes an AXI4-Lite byte address of 8 bits, one 32-bit word per register
`ifndef PIN_IRQ_CFG_SVH
`define PIN_IRQ_CFG_SVH
`define OFS_EXTCTL   8'h00
`define OFS_PIE      8'h04
`define OFS_PPS      8'h08
`define OFS_PIF      8'h0C
`define OFS_OCCTL    8'h10
`define OFS_OCFLAG   8'h14
`define OFS_HVCTL    8'h18
`define OFS_HVSTAT   8'h1C
`define EXT_EN_BIT   0
`define EXT_FALL_BIT 1
`define EXT_FLAG_BIT 2
`define OC_EN_BIT    0
`define HV_DIEN_BIT  0
`define HV_AEN_BIT   1
`define HV_DIRB_BIT  2
`define HV_CBYP_BIT  3
`define HV_RATIO_BIT 4
`define HV_TEST_BIT  5
`define HV_POL_BIT   6
`define HV_EN_BIT    7
`define HV_STATE_BIT 0
`define HV_FLAG_BIT  1
`define HVCTL_RESET  8'h00
`define FILT_LEN     3'h4
`define FILT_LAST    3'h3
`define RC_DIV       8
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// >>> src/pin_irq_pkg.sv
// types shared by the pin interrupt block and its bench
// assumes 32-bit AXI4-Lite data and 8-bit byte addresses
package pin_irq_pkg;
   typedef logic [31:0] word_t;
   typedef logic [7:0]  addr_t;
   typedef logic [2:0]  count_t;
endpackage

// >>> src/port_pin_interrupt_and_hv_input.sv
// holds the whole block: AXI4-Lite slave, filters, flags and hv input control
// assumes pins already synchronous to clk_sys; stop and wait levels come from power control
`timescale 1ns/100ps
`include "pin_irq_cfg.svh"
module port_pin_interrupt_and_hv_input #(
   parameter int NPORT  = 4,
   parameter int NOC    = 5,
   parameter int RC_DIV = `RC_DIV
) (
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               sys_rst,
   // AXI4-Lite slave
   input  wire pin_irq_pkg::addr_t awaddr,
   input  wire logic               awvalid,
   output logic                    awready,
   input  wire pin_irq_pkg::word_t wdata,
   input  wire logic [3:0]         wstrb,
   input  wire logic               wvalid,
   output logic                    wready,
   output logic [1:0]              bresp,
   output logic                    bvalid,
   input  wire logic               bready,
   input  wire pin_irq_pkg::addr_t araddr,
   input  wire logic               arvalid,
   output logic                    arready,
   output pin_irq_pkg::word_t      rdata,
   output logic [1:0]              rresp,
   output logic                    rvalid,
   input  wire logic               rready,
   // external pins
   input  wire logic               nonmaskableRequestPin_n,
   input  wire logic               extRequestPin_n,
   input  wire logic [NPORT*8-1:0] portPin,
   input  wire logic               highVoltageInput,
   input  wire logic [NOC-1:0]     overcurrentDetect,
   // cpu and power state
   input  wire logic               cpuIntMask,
   input  wire logic               stopMode,
   input  wire logic               waitMode,
   // requests and wakeup
   output logic                    nmiMaskSet,
   output logic                    nmiRequest,
   output logic                    extRequest,
   output logic [NPORT-1:0]        portRequest,
   output logic                    overcurrentRequest,
   output logic                    hvRequest,
   output logic                    keyWakeup,
   output logic                    rcOscRun,
   // pin drive and hv analog path
   output logic [NOC-1:0]          overcurrentForce,
   output logic                    hvDigitalBufferOn,
   output logic                    hvAdcRoute,
   output logic                    hvDividerBypassOut,
   output logic                    hvConverterBypassOut,
   output logic                    hvRatioSelectOut
);
   import pin_irq_pkg::*;
   localparam int NPIN = NPORT * 8;
   localparam int NF   = NPIN + 1;

   function automatic word_t mergeBytes(input word_t old, input word_t val,
                                        input logic [3:0] strb);
      word_t res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) res[b*8 +: 8] = val[b*8 +: 8];
      end
      return res;
   endfunction

   // bus slave state
   addr_t            wrAddr;
   word_t            wrData;
   logic [3:0]       wrStrb;
   // control registers
   logic [2:0]       extCtl;
   logic             extPrev;
   logic [NPIN-1:0]  pinEventEnable;
   logic [NPIN-1:0]  pinEdgePolarity;
   logic [NPIN-1:0]  pinEventFlag;
   logic             overcurrentEventEnable;
   logic [NOC-1:0]   overcurrentFlag;
   logic [7:0]       hvCtl;
   logic             hvEventFlag;
   logic             hvInputState;
   // filters
   count_t           pasCnt [NF];
   count_t           actCnt [NF];
   logic [NF-1:0]    filtEvent;
   logic [$clog2(RC_DIV+1)-1:0] rcCnt;

   wire doWrite = !awready && !wready && !bvalid;
   wire wrExt   = doWrite && wrAddr == `OFS_EXTCTL;
   wire wrPie   = doWrite && wrAddr == `OFS_PIE;
   wire wrPps   = doWrite && wrAddr == `OFS_PPS;
   wire wrPif   = doWrite && wrAddr == `OFS_PIF;
   wire wrOcCtl = doWrite && wrAddr == `OFS_OCCTL;
   wire wrOcFlg = doWrite && wrAddr == `OFS_OCFLAG;
   wire wrHvCtl = doWrite && wrAddr == `OFS_HVCTL;
   wire wrHvSt  = doWrite && wrAddr == `OFS_HVSTAT;
   wire word_t wrMerged = mergeBytes(32'h00000000, wrData, wrStrb);
   wire wrMapped = wrExt || wrPie || wrPps || wrPif || wrOcCtl || wrOcFlg || wrHvCtl
                   || wrHvSt;

   wire hvDien = hvCtl[`HV_DIEN_BIT];
   wire hvAen  = hvCtl[`HV_AEN_BIT];
   wire hvDirb = hvCtl[`HV_DIRB_BIT];
   wire hvTest = hvCtl[`HV_TEST_BIT];
   // stop here means the reduced_performance_regulator stop only
   wire hvBuf = stopMode ? hvDien
              : (hvDien && !hvAen) || (hvAen && hvTest && !hvDirb);
   wire hvDigital = hvDien && !hvAen;

   wire extEn      = extCtl[`EXT_EN_BIT];
   wire extFalling = extCtl[`EXT_FALL_BIT];
   wire extEdge    = extPrev && !extRequestPin_n;
   wire extPending = extFalling ? extCtl[`EXT_FLAG_BIT] : !extRequestPin_n;
   wire [NPIN-1:0] pinArmed = pinEventEnable & ~pinEventFlag;
   wire hvEventEnable = hvCtl[`HV_EN_BIT];
   // counts never pass four, so any armed pin keeps the oscillator running
   wire oscWanted = stopMode && (|pinArmed || (hvEventEnable && !hvEventFlag && hvBuf));
   wire rcTick = oscWanted && rcCnt == ($bits(rcCnt))'(RC_DIV - 1);
   wire sampleTick = stopMode ? rcTick : 1'b1;
   wire [NF-1:0] filtIn  = {hvBuf && highVoltageInput, portPin};
   wire [NF-1:0] filtPol = {hvCtl[`HV_POL_BIT], pinEdgePolarity};
   wire [NF-1:0] filtOn  = {hvBuf, {NPIN{1'b1}}};
   wire anyPinReq = |(pinEventFlag & pinEventEnable) || (hvEventFlag && hvEventEnable);

   // AXI4-Lite: address and data taken in either order, response once both are held
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         bvalid  <= 1'b0;
         bresp   <= `RESP_OKAY;
         wrAddr  <= 8'h00;
         wrData  <= 32'h00000000;
         wrStrb  <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            wrAddr  <= awaddr;
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            wrData <= wdata;
            wrStrb <= wstrb;
         end
         if (doWrite) begin
            bvalid  <= 1'b1;
            bresp   <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   wire word_t rdMux =
        araddr == `OFS_EXTCTL ? {29'h0, extCtl}
      : araddr == `OFS_PIE    ? word_t'(pinEventEnable)
      : araddr == `OFS_PPS    ? word_t'(pinEdgePolarity)
      : araddr == `OFS_PIF    ? word_t'(pinEventFlag)
      : araddr == `OFS_OCCTL  ? {31'h0, overcurrentEventEnable}
      : araddr == `OFS_OCFLAG ? word_t'(overcurrentFlag)
      : araddr == `OFS_HVCTL  ? {24'h0, hvCtl}
      : araddr == `OFS_HVSTAT ? {30'h0, hvEventFlag, hvInputState}
      : 32'h00000000;
   wire rdMapped = araddr[7:5] == 3'h0 && araddr[1:0] == 2'h0;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h00000000;
         rresp   <= `RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rdMux;
         rresp   <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // control registers; hardware set wins over a write-one clear
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         extCtl                 <= 3'h0;
         extPrev                <= 1'b1;
         pinEventEnable         <= '0;
         pinEdgePolarity        <= '0;
         pinEventFlag           <= '0;
         overcurrentEventEnable <= 1'b0;
         overcurrentFlag        <= '0;
         hvCtl                  <= `HVCTL_RESET;
         hvEventFlag            <= 1'b0;
         hvInputState           <= 1'b0;
      end else begin
         extPrev <= extRequestPin_n;
         if (wrExt) begin
            extCtl[1:0] <= wrMerged[1:0];
         end
         // flag follows only while enabled, so a cleared enable drops it
         extCtl[`EXT_FLAG_BIT] <= (wrExt ? wrMerged[`EXT_EN_BIT] : extEn)
            && (extEdge || (extCtl[`EXT_FLAG_BIT] && !(wrExt && wrMerged[`EXT_FLAG_BIT])));
         if (wrPie) pinEventEnable <= wrMerged[NPIN-1:0];
         if (wrPps) pinEdgePolarity <= wrMerged[NPIN-1:0];
         pinEventFlag <= (pinEventFlag & ~(wrPif ? wrMerged[NPIN-1:0] : '0))
                         | filtEvent[NPIN-1:0];
         if (wrOcCtl) overcurrentEventEnable <= wrMerged[`OC_EN_BIT];
         overcurrentFlag <= (overcurrentFlag & ~(wrOcFlg ? wrMerged[NOC-1:0] : '0))
                            | overcurrentDetect;
         if (wrHvCtl) hvCtl <= wrMerged[7:0];
         hvEventFlag <= (hvEventFlag && !(wrHvSt && wrMerged[`HV_FLAG_BIT]))
                        || filtEvent[NPIN];
         hvInputState <= hvBuf && highVoltageInput;
      end
   end

   // RC oscillator modelled as a divider that only counts while armed
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !oscWanted || rcTick) rcCnt <= '0;
      else rcCnt <= rcCnt + 1'b1;
   end

   // glitch filters: passive run of four, then active run of four
   genvar i;
   generate
      for (i = 0; i < NF; i++) begin : g_filt
         wire active = filtIn[i] == filtPol[i];
         assign filtEvent[i] = sampleTick && filtOn[i] && active
                               && pasCnt[i] == `FILT_LEN && actCnt[i] == `FILT_LAST;
         always_ff @(posedge clk_sys) begin
            if (sys_rst || !filtOn[i] || filtEvent[i]) begin
               pasCnt[i] <= 3'h0;
               actCnt[i] <= 3'h0;
            end else if (sampleTick) begin
               if (!active) begin
                  pasCnt[i] <= actCnt[i] != 3'h0 ? 3'h1
                             : pasCnt[i] == `FILT_LEN ? `FILT_LEN : pasCnt[i] + 3'h1;
                  actCnt[i] <= 3'h0;
               end else if (pasCnt[i] == `FILT_LEN) begin
                  actCnt[i] <= actCnt[i] + 3'h1;
               end else begin
                  pasCnt[i] <= 3'h0;
                  actCnt[i] <= 3'h0;
               end
            end
         end
      end
      for (i = 0; i < NPORT; i++) begin : g_port
         always_ff @(posedge clk_sys) begin
            if (sys_rst) portRequest[i] <= 1'b0;
            else portRequest[i] <= |(pinEventFlag[i*8 +: 8]
                                     & pinEventEnable[i*8 +: 8]);
         end
      end
   endgenerate

   // request, wakeup and drive outputs
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         nmiMaskSet           <= 1'b1;
         nmiRequest           <= 1'b0;
         extRequest           <= 1'b0;
         overcurrentRequest   <= 1'b0;
         hvRequest            <= 1'b0;
         keyWakeup            <= 1'b0;
         rcOscRun             <= 1'b0;
         overcurrentForce     <= '0;
         hvDigitalBufferOn    <= 1'b0;
         hvAdcRoute           <= 1'b0;
         hvDividerBypassOut   <= 1'b0;
         hvConverterBypassOut <= 1'b0;
         hvRatioSelectOut     <= 1'b0;
      end else begin
         nmiMaskSet <= 1'b0;
         // the cpu keeps its own mask; the pin itself is always forwarded
         nmiRequest <= !nonmaskableRequestPin_n;
         extRequest <= extEn && !cpuIntMask && extPending;
         overcurrentRequest <= overcurrentEventEnable && |overcurrentFlag;
         hvRequest <= hvEventFlag && hvEventEnable && hvDigital;
         // unfiltered external pins wake directly
         keyWakeup <= (stopMode || waitMode) && (!nonmaskableRequestPin_n
                      || (extEn && extPending) || anyPinReq);
         rcOscRun <= oscWanted;
         overcurrentForce <= overcurrentFlag | overcurrentDetect;
         hvDigitalBufferOn <= hvBuf;
         hvAdcRoute <= hvAen && !stopMode;
         hvDividerBypassOut <= hvDirb;
         hvConverterBypassOut <= hvDirb && hvCtl[`HV_CBYP_BIT];
         hvRatioSelectOut <= hvCtl[`HV_RATIO_BIT];
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   chk_mask_in_reset: assert property (@(posedge clk_sys) disable iff (1'b0)
                                       sys_rst |=> nmiMaskSet)
      else $error("mask bit not set during reset");
   chk_ext_disabled: assert property (!extEn |=> !extRequest)
      else $error("maskable request without enable");
   chk_ext_level: assert property (extEn && !extFalling && !cpuIntMask
                                   && !extRequestPin_n |=> extRequest)
      else $error("low level did not request");
   chk_port_request: assert property (|(pinEventFlag[7:0] & pinEventEnable[7:0])
                                      |=> portRequest[0])
      else $error("port request missing");
   chk_filter_flag: assert property (filtEvent[0] |=> pinEventFlag[0])
      else $error("filtered edge did not set flag");
   chk_filter_runs: assert property (filtEvent[0] |-> $past(pasCnt[0]) == `FILT_LEN)
      else $error("edge without passive run");
   chk_osc_stop: assert property (!stopMode |=> !rcOscRun)
      else $error("oscillator running outside stop");
   chk_oc_force: assert property (overcurrentDetect[1] |=> overcurrentForce[1] [*2])
      else $error("over-current did not force output");
   chk_hv_analog: assert property (hvAen && !hvTest && !stopMode |=> !hvDigitalBufferOn)
      else $error("digital buffer on in analog mode");
   chk_hv_reset: assert property (@(posedge clk_sys) disable iff (1'b0)
                                  sys_rst |=> !hvDigitalBufferOn)
      else $error("hv buffer on after reset");
   chk_ext_withdraw: assert property (wrExt && !wrMerged[`EXT_EN_BIT]
                                      |=> !extCtl[`EXT_FLAG_BIT])
      else $error("pending request kept after enable clear");
   chk_ext_masked: assert property (cpuIntMask |=> !extRequest)
      else $error("maskable request while cpu masked");
   chk_nmi_forward: assert property (!nonmaskableRequestPin_n |=> nmiRequest)
      else $error("low non-maskable pin not forwarded");
   chk_wake_idle: assert property (!stopMode && !waitMode |=> !keyWakeup)
      else $error("wakeup outside stop or wait");
   chk_flag_clear: assert property (wrPif && wrMerged[0] && !filtEvent[0]
                                    |=> !pinEventFlag[0])
      else $error("write-one did not clear pin flag");
   chk_osc_armed: assert property (stopMode && |pinArmed |=> rcOscRun)
      else $error("oscillator idle while pin armed");
   chk_oc_request: assert property (overcurrentEventEnable && |overcurrentFlag
                                    |=> overcurrentRequest)
      else $error("enabled over-current flag did not request");
   chk_hv_flag_set: assert property (filtEvent[NPIN] |=> hvEventFlag)
      else $error("hv edge did not set flag");
   chk_hv_stop_buf: assert property (stopMode |=> hvDigitalBufferOn == $past(hvDien))
      else $error("stop buffer not following digital enable");
endmodule

// >>> testbench/pin_world_model.sv
// models the pins, switches and sensors that face the pin interrupt block
// assumes the bench calls hold and setOc from its own sequence, one call at a time
`timescale 1ns/100ps
module pin_world_model (
   // clock
   input  wire logic  clk_sys,
   // pins toward the block
   output logic [31:0] portPin,
   output logic        highVoltageInput,
   output logic        nonmaskableRequestPin_n,
   output logic        extRequestPin_n,
   output logic [4:0]  overcurrentDetect
);
   // lines 0..31 port pins, 32 hv input, 33 and 34 the active-low request pins
   logic [34:0] lines = '1;
   logic [4:0]  detect = 5'h00;

   assign portPin = lines[31:0];
   assign highVoltageInput = lines[32];
   assign nonmaskableRequestPin_n = lines[33];
   assign extRequestPin_n = lines[34];
   assign overcurrentDetect = detect;

   // the level is sampled at exactly n rising edges before the next call may change it
   task automatic hold(input int idx, input logic lvl, input int n);
      @(posedge clk_sys);
      lines[idx] <= lvl;
      repeat (n - 1) @(posedge clk_sys);
   endtask

   task automatic setOc(input logic [4:0] v);
      @(posedge clk_sys);
      detect <= v;
   endtask
endmodule

// >>> testbench/port_pin_interrupt_and_hv_input_test.sv
// self-checking bench for the pin interrupt block: bus tasks, one task per scenario
// assumes the block answers on AXI4-Lite and the pin model drives all external pins
`timescale 1ns/100ps
`include "pin_irq_cfg.svh"
module port_pin_interrupt_and_hv_input_test;
   import pin_irq_pkg::*;
   localparam int HV = 32;
   localparam int NMI = 33;
   localparam int EXT = 34;
   logic        clk_sys = 1'h0;
   logic        sys_rst = 1'h1, cpuIntMask = 1'h1, stopMode = 1'h0, waitMode = 1'h0;
   addr_t       awaddr = 8'h00, araddr = 8'h00;
   word_t       wdata = 32'h0, rdata;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, lastResp;
   logic        nmiMaskSet, nmiRequest, extRequest, overcurrentRequest, hvRequest;
   logic        keyWakeup, rcOscRun, hvDigitalBufferOn, hvAdcRoute;
   logic        hvDividerBypassOut, hvConverterBypassOut, hvRatioSelectOut;
   logic [3:0]  portRequest;
   logic [4:0]  overcurrentForce, overcurrentDetect;
   logic [31:0] portPin;
   logic        highVoltageInput, nonmaskableRequestPin_n, extRequestPin_n;
   int          failures = 0, n_tests = 0;

   always #5 clk_sys = ~clk_sys;

   // stop-mode sample divider shortened so stop scenarios stay brief
   port_pin_interrupt_and_hv_input #(.RC_DIV(2)) dut_u (
      .clk_sys, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .nonmaskableRequestPin_n, .extRequestPin_n, .portPin,
      .highVoltageInput, .overcurrentDetect, .cpuIntMask, .stopMode, .waitMode,
      .nmiMaskSet, .nmiRequest, .extRequest, .portRequest, .overcurrentRequest,
      .hvRequest, .keyWakeup, .rcOscRun, .overcurrentForce, .hvDigitalBufferOn,
      .hvAdcRoute, .hvDividerBypassOut, .hvConverterBypassOut, .hvRatioSelectOut);

   pin_world_model pins_u (.clk_sys, .portPin, .highVoltageInput,
      .nonmaskableRequestPin_n, .extRequestPin_n, .overcurrentDetect);

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // handshake signals are sampled in the active region, before the block's updates land
   task automatic wr(input addr_t a, input word_t d);
      logic b;
      b = 1'h0;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (int n = 0; n < 100 && !b; n++) begin
         @(posedge clk_sys);
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
         b = (bvalid === 1'h1);
         lastResp = bresp;
         if (b) bready <= 1'h0;
      end
      if (!b) begin
         failures++;
         stop_test();
      end
   endtask

   task automatic rchk(input addr_t a, input word_t e);
      logic r;
      r = 1'h0;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (int n = 0; n < 100 && !r; n++) begin
         @(posedge clk_sys);
         if (arready === 1'h1) arvalid <= 1'h0;
         r = (rvalid === 1'h1);
         lastResp = rresp;
         if (r) rready <= 1'h0;
         if (r) chk($sformatf("reg %h", a), e, rdata);
      end
      if (!r) begin
         failures++;
         stop_test();
      end
   endtask

   task automatic t_bus;
      rchk(`OFS_HVCTL, 32'h0);
      rchk(8'h40, 32'h0);
      chk("rresp", 32'h2, lastResp);
      wr(8'h40, 32'hFFFF_FFFF);
      chk("bresp", 32'h2, lastResp);
   endtask

   task automatic t_ext;
      wr(`OFS_EXTCTL, 32'h1);
      pins_u.hold(EXT, 1'h0, 1);
      tick(3);
      chk("extRequest", 32'h0, extRequest);
      @(posedge clk_sys);
      cpuIntMask <= 1'h0;
      tick(2);
      chk("extRequest", 32'h1, extRequest);
      pins_u.hold(EXT, 1'h1, 2);
      tick(2);
      chk("extRequest", 32'h0, extRequest);
      wr(`OFS_EXTCTL, 32'h3);
      pins_u.hold(EXT, 1'h0, 1);
      pins_u.hold(EXT, 1'h1, 1);
      tick(3);
      rchk(`OFS_EXTCTL, 32'h7);
      chk("extRequest", 32'h1, extRequest);
      wr(`OFS_EXTCTL, 32'h2);
      tick(1);
      chk("extRequest", 32'h0, extRequest);
      rchk(`OFS_EXTCTL, 32'h2);
      // a one-sample pulse must get through, since these pins bypass the filters
      pins_u.hold(NMI, 1'h0, 1);
      pins_u.hold(NMI, 1'h1, 1);
      #1;
      chk("nmiRequest", 32'h1, nmiRequest);
      tick(1);
      chk("nmiRequest", 32'h0, nmiRequest);
   endtask

   task automatic t_pins;
      wr(`OFS_PPS, 32'h0);
      wr(`OFS_PIE, 32'h1);
      pins_u.hold(0, 1'h0, 3);
      pins_u.hold(0, 1'h1, 4);
      tick(3);
      rchk(`OFS_PIF, 32'h0);
      pins_u.hold(0, 1'h0, 4);
      tick(3);
      rchk(`OFS_PIF, 32'h1);
      chk("portRequest", 32'h1, portRequest);
      wr(`OFS_PIF, 32'h0);
      rchk(`OFS_PIF, 32'h1);
      wr(`OFS_PIF, 32'h1);
      rchk(`OFS_PIF, 32'h0);
      chk("portRequest", 32'h0, portRequest);
   endtask

   task automatic t_stop;
      wr(`OFS_PIE, 32'h100);
      wr(`OFS_PPS, 32'h100);
      @(posedge clk_sys);
      stopMode <= 1'h1;
      pins_u.hold(8, 1'h0, 20);
      // five bus cycles pass the run filter but are under four stop samples
      pins_u.hold(8, 1'h1, 5);
      pins_u.hold(8, 1'h0, 20);
      tick(1);
      chk("portRequest", 32'h0, portRequest);
      chk("rcOscRun", 32'h1, rcOscRun);
      pins_u.hold(8, 1'h1, 20);
      tick(2);
      chk("keyWakeup", 32'h1, keyWakeup);
      chk("portRequest", 32'h2, portRequest);
      chk("rcOscRun", 32'h0, rcOscRun);
      @(posedge clk_sys);
      stopMode <= 1'h0;
      tick(2);
      chk("keyWakeup", 32'h0, keyWakeup);
      @(posedge clk_sys);
      waitMode <= 1'h1;
      tick(2);
      chk("keyWakeup", 32'h1, keyWakeup);
      @(posedge clk_sys);
      waitMode <= 1'h0;
      wr(`OFS_PIF, 32'h100);
   endtask

   task automatic t_oc;
      pins_u.setOc(5'h02);
      tick(2);
      chk("overcurrentForce", 32'h2, overcurrentForce);
      chk("overcurrentRequest", 32'h0, overcurrentRequest);
      rchk(`OFS_OCFLAG, 32'h2);
      wr(`OFS_OCCTL, 32'h1);
      tick(1);
      chk("overcurrentRequest", 32'h1, overcurrentRequest);
      pins_u.setOc(5'h00);
      tick(2);
      chk("overcurrentForce", 32'h2, overcurrentForce);
      wr(`OFS_OCFLAG, 32'h0);
      rchk(`OFS_OCFLAG, 32'h2);
      wr(`OFS_OCFLAG, 32'h2);
      tick(1);
      chk("overcurrentForce", 32'h0, overcurrentForce);
      chk("overcurrentRequest", 32'h0, overcurrentRequest);
   endtask

   task automatic t_hv;
      wr(`OFS_HVCTL, 32'hC1);
      pins_u.hold(HV, 1'h0, 8);
      pins_u.hold(HV, 1'h1, 8);
      tick(3);
      rchk(`OFS_HVSTAT, 32'h3);
      chk("hvRequest", 32'h1, hvRequest);
      chk("hvDigitalBufferOn", 32'h1, hvDigitalBufferOn);
      wr(`OFS_HVSTAT, 32'h2);
      wr(`OFS_HVCTL, 32'h03);
      tick(1);
      chk("hvDigitalBufferOn", 32'h0, hvDigitalBufferOn);
      chk("hvAdcRoute", 32'h1, hvAdcRoute);
      wr(`OFS_HVCTL, 32'h23);
      tick(1);
      chk("hvDigitalBufferOn", 32'h1, hvDigitalBufferOn);
      wr(`OFS_HVCTL, 32'h3F);
      tick(1);
      chk("hvDigitalBufferOn", 32'h0, hvDigitalBufferOn);
      chk("analog path", 32'h7, {hvDividerBypassOut, hvConverterBypassOut, hvRatioSelectOut});
      wr(`OFS_HVCTL, 32'h03);
      stopMode <= 1'h1;
      tick(2);
      chk("hvDigitalBufferOn", 32'h1, hvDigitalBufferOn);
      // an unfiltered low on the non-maskable pin must wake from stop
      pins_u.hold(NMI, 1'h0, 2);
      #1;
      chk("keyWakeup", 32'h1, keyWakeup);
      pins_u.hold(NMI, 1'h1, 1);
      wr(`OFS_HVCTL, 32'h02);
      tick(1);
      chk("hvDigitalBufferOn", 32'h0, hvDigitalBufferOn);
      @(posedge clk_sys);
      stopMode <= 1'h0;
      wr(`OFS_HVCTL, 32'h03);
      tick(1);
      chk("hvDigitalBufferOn", 32'h0, hvDigitalBufferOn);
   endtask

   initial begin
      repeat (20) @(posedge clk_sys);
      #1;
      chk("nmiMaskSet", 32'h1, nmiMaskSet);
      chk("hvDigitalBufferOn", 32'h0, hvDigitalBufferOn);
      @(posedge clk_sys);
      sys_rst <= 1'h0;
      tick(1);
      chk("extRequest", 32'h0, extRequest);
      t_bus();
      t_ext();
      t_pins();
      t_stop();
      t_oc();
      t_hv();
      stop_test();
   end
endmodule
